// ---- sarc_clk_div.sv ----
// conversion clock divider: one-cycle tick every divider+1 system clocks
// assumes div is static while running; held in reset when run is low
`include "sarc_consts.svh"
module sarc_clk_div #(
    parameter int DIV_BITS = `SARC_DIV_BITS
) (
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    input  wire logic                run,
    input  wire logic [DIV_BITS-1:0] div,
    output logic                     tick
);
    logic [DIV_BITS-1:0] count_q;
    logic [DIV_BITS-1:0] count_d;
    logic                wrap;

    generate
        if (DIV_BITS < 1) begin : g_chk
            $error("sarc_clk_div needs at least one divider bit");
        end
    endgenerate

    assign wrap    = (count_q >= div);
    assign count_d = wrap ? '0 : count_q + 1'b1;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else if (!run) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else begin
            count_q <= count_d; // R10
            tick    <= wrap; // R10
        end
    end
endmodule // sarc_clk_div

// ---- sarc_cmp_model.sv ----
// comparator model for the far side of the trial-code output
// assumes level is the input as an offset-binary code, held by the bench
module sarc_cmp_model (
    input  wire logic [9:0] sar_trial_code,
    input  wire logic [9:0] level,
    output logic            cmp_above
);
    // answers within the cycle, as the sar expects on every tick
    assign cmp_above = level >= sar_trial_code;
endmodule // sarc_cmp_model

// ---- sarc_consts.svh ----
// constants for the converter control: encodings, counts and reset values
// assumes the including file sits in the same folder; definitions only
// Operation
// [R1] enable bit low holds converter in shutdown
// [R2] ground negative input selects single-ended mode
// [R3] single-ended result is 10-bit unsigned code
// [R4] justify bit selects right or left placement
// [R5] single-ended unused result bits read zero
// [R6] differential result is 10-bit two's complement
// [R7] right-justified differential sign-extends high byte
// [R8] left-justified differential zero-fills low byte; code zeroes only its low six bits, value[1:0] sits in bits 7:6
// [R9] result bytes update at conversion completion
// [R10] conversion clock is system clock over divider+1
// [R11] start field picks one of six triggers
// [R12] software busy write starts conversion on demand
// [R13] busy reads one during conversion only
// [R14] busy falling sets done flag, interrupt
// [R15] software polls done flag for valid data
// [R16] timer 2/3 overflow byte follows timer width
// [R17] external pin rising edge starts conversion
// [R18] default tracking continuous except while converting
// [R19] low-power tracking adds three conversion clocks
// [R20] low-power external start tracks while pin low
// [R21] start codes 000-101 in order, others idle
// [R22] starts ignored while busy; fixed conversion length
`ifndef SARC_CONSTS_SVH
`define SARC_CONSTS_SVH

`define SARC_RES_BITS        10
`define SARC_DIV_BITS        5
`define SARC_DIV_MAX         5'h1f
`define SARC_TRACK_CLOCKS    2'h3
`define SARC_BIT_IDX_RESET   4'h0
`define SARC_MSB_IDX         4'h9
`define SARC_TRIAL_START     10'h200
`define SARC_NEG_GND_DEFAULT 5'h1f

`define SARC_SRC_SOFTWARE    3'h0
`define SARC_SRC_TIMER0      3'h1
`define SARC_SRC_TIMER2      3'h2
`define SARC_SRC_TIMER1      3'h3
`define SARC_SRC_EXTERNAL    3'h4
`define SARC_SRC_TIMER3      3'h5

`define SARC_RESULT_RESET    8'h00
`define SARC_TRIAL_RESET     10'h000

`endif

// ---- sarc_ctrl.sv ----
// converter control top: start selection, tracking, sar sequencing, result
// assumes all inputs synchronous to ref_clk; comparator answers each tick
`include "sarc_consts.svh"
module sarc_ctrl #(
    parameter int         RES_BITS     = `SARC_RES_BITS,
    parameter logic [4:0] NEG_GND_CODE = `SARC_NEG_GND_DEFAULT
) (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire logic                  converter_enable_bit,
    input  wire logic [4:0]            negative_input_select,
    input  wire logic                  justify_select_bit,
    input  wire logic [4:0]            conv_clock_divider,
    input  wire sarc_pkg::sarc_src_t   start_source_field,
    input  wire logic                  tracking_mode_bit,
    input  wire logic                  busy_write_one,
    input  wire logic                  done_clear,
    input  wire logic                  int_enable,
    input  wire logic                  timer0_ovf,
    input  wire logic                  timer1_ovf,
    input  wire logic                  timer2_low_ovf,
    input  wire logic                  timer2_high_ovf,
    input  wire logic                  timer2_split8,
    input  wire logic                  timer3_low_ovf,
    input  wire logic                  timer3_high_ovf,
    input  wire logic                  timer3_split8,
    input  wire logic                  external_start_pin,
    input  wire logic                  cmp_above,
    output logic                       conversion_busy_bit,
    output logic                       conversion_done_flag,
    output logic                       interrupt_request,
    output logic                       track_active,
    output logic                       single_ended_mode,
    output logic [RES_BITS-1:0]        sar_trial_code,
    output logic [7:0]                 result_high_byte,
    output logic [7:0]                 result_low_byte
);
    import sarc_pkg::*;

    generate
        if (RES_BITS != 10) begin : g_chk
            $error("sarc_ctrl serves a 10-bit result only");
        end
    endgenerate

    sarc_state_t         state_q;
    sarc_state_t         state_d;
    logic [1:0]          track_cnt_q;
    logic [1:0]          track_cnt_d;
    logic [3:0]          bit_idx_q;
    logic [3:0]          bit_idx_d;
    logic [RES_BITS-1:0] trial_d;
    logic                pin_prev_q;
    logic                busy_d;
    logic                done_d;
    logic                track_d;
    logic [7:0]          high_d;
    logic [7:0]          low_d;

    wire                 enabled;
    wire                 tick;
    wire                 pin_rise;
    wire                 timer2_evt;
    wire                 timer3_evt;
    wire                 start_evt;
    wire                 ext_lowpower;
    wire                 track_done;
    wire                 last_bit;
    wire                 finish;
    wire [RES_BITS-1:0]  final_code;
    wire [RES_BITS-1:0]  decided;
    wire [7:0]           fmt_high;
    wire [7:0]           fmt_low;
    wire                 diff_mode;

    assign enabled   = converter_enable_bit; // R1
    assign diff_mode = (negative_input_select != NEG_GND_CODE); // R2

    sarc_clk_div #(
        .DIV_BITS (`SARC_DIV_BITS)
    ) u_div (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .run     (enabled),
        .div     (conv_clock_divider),
        .tick    (tick)
    );

    // start trigger selection
    assign pin_rise   = external_start_pin & ~pin_prev_q; // R17
    assign timer2_evt = timer2_split8 ? timer2_low_ovf : timer2_high_ovf; // R16
    assign timer3_evt = timer3_split8 ? timer3_low_ovf : timer3_high_ovf; // R16

    assign start_evt =
        (start_source_field == `SARC_SRC_SOFTWARE) ? busy_write_one : // R11 R12 R21
        (start_source_field == `SARC_SRC_TIMER0)   ? timer0_ovf     : // R11 R21
        (start_source_field == `SARC_SRC_TIMER2)   ? timer2_evt     : // R11 R21
        (start_source_field == `SARC_SRC_TIMER1)   ? timer1_ovf     : // R11 R21
        (start_source_field == `SARC_SRC_EXTERNAL) ? pin_rise       : // R11 R17 R21
        (start_source_field == `SARC_SRC_TIMER3)   ? timer3_evt     : // R11 R21
        1'b0; // R21

    // with the pin as trigger in low-power mode, tracking already ran while the pin was low
    assign ext_lowpower = tracking_mode_bit && (start_source_field == `SARC_SRC_EXTERNAL); // R20

    assign track_done = tick && (track_cnt_q == `SARC_TRACK_CLOCKS - 2'h1); // R19
    assign last_bit   = (bit_idx_q == `SARC_BIT_IDX_RESET);
    assign finish     = (state_q == st_convert) && tick && last_bit; // R22

    // current trial bit kept or dropped by the comparator
    assign decided    = cmp_above ? sar_trial_code : (sar_trial_code & ~(10'h001 << bit_idx_q));
    assign final_code = decided;

    sarc_fmt u_fmt (
        .code      (final_code),
        .diff_mode (diff_mode),
        .left_just (justify_select_bit),
        .high_byte (fmt_high),
        .low_byte  (fmt_low)
    );

    // sequencing
    always_comb begin
        state_d     = state_q;
        track_cnt_d = track_cnt_q;
        bit_idx_d   = bit_idx_q;
        trial_d     = sar_trial_code;
        case (state_q)
            st_idle: begin
                if (enabled && start_evt) begin
                    if (tracking_mode_bit && !ext_lowpower) begin
                        state_d     = st_track; // R19
                        track_cnt_d = 2'h0;
                    end else begin
                        state_d   = st_convert; // R18 R20
                        bit_idx_d = `SARC_MSB_IDX;
                        trial_d   = `SARC_TRIAL_START;
                    end
                end
            end
            st_track: begin
                if (tick) begin
                    track_cnt_d = track_cnt_q + 2'h1;
                end
                if (track_done) begin
                    state_d   = st_convert; // R19
                    bit_idx_d = `SARC_MSB_IDX;
                    trial_d   = `SARC_TRIAL_START;
                end
            end
            st_convert: begin
                if (tick) begin
                    if (last_bit) begin
                        state_d = st_idle; // R22
                        trial_d = decided;
                    end else begin
                        bit_idx_d = bit_idx_q - 4'h1;
                        trial_d   = decided | (10'h001 << (bit_idx_q - 4'h1));
                    end
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
        if (!enabled) begin
            state_d = st_idle; // R1
        end
    end

    assign busy_d = (state_d != st_idle); // R13 R22
    assign done_d = finish | (conversion_done_flag & ~done_clear); // R14 R15

    assign track_d = !enabled           ? 1'b0 : // R1
        (state_d == st_convert)          ? 1'b0 : // R18
        (state_d == st_track)            ? 1'b1 : // R19
        ext_lowpower                     ? ~external_start_pin : // R20
        ~tracking_mode_bit; // R18

    assign high_d = finish ? fmt_high : result_high_byte; // R9
    assign low_d  = finish ? fmt_low  : result_low_byte; // R9

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q     <= st_idle;
            track_cnt_q <= 2'h0;
            bit_idx_q   <= `SARC_BIT_IDX_RESET;
            pin_prev_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            track_cnt_q <= track_cnt_d;
            bit_idx_q   <= bit_idx_d;
            pin_prev_q  <= external_start_pin;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            conversion_busy_bit  <= 1'b0;
            conversion_done_flag <= 1'b0;
            interrupt_request    <= 1'b0;
            track_active         <= 1'b0;
            single_ended_mode    <= 1'b0;
        end else begin
            conversion_busy_bit  <= busy_d; // R13
            conversion_done_flag <= done_d; // R14
            interrupt_request    <= done_d & int_enable; // R14
            track_active         <= track_d;
            single_ended_mode    <= ~diff_mode; // R2
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sar_trial_code   <= `SARC_TRIAL_RESET;
            result_high_byte <= `SARC_RESULT_RESET;
            result_low_byte  <= `SARC_RESULT_RESET;
        end else begin
            sar_trial_code   <= trial_d;
            result_high_byte <= high_d; // R9
            result_low_byte  <= low_d; // R9
        end
    end
endmodule // sarc_ctrl

// ---- sarc_ctrl_asserts.sv ----
// concurrent checks on the converter control top ports
// assumes a bind onto sarc_ctrl, one clock, async active-low reset
module sarc_ctrl_asserts
    import sarc_pkg::*;
#(
    parameter logic [4:0] NEG_GND_CODE = 5'h1f
) (
    input wire logic               ref_clk,
    input wire logic               nrst,
    input wire logic               converter_enable_bit,
    input wire logic [4:0]         negative_input_select,
    input wire logic [4:0]         conv_clock_divider,
    input wire sarc_pkg::sarc_src_t start_source_field,
    input wire logic               tracking_mode_bit,
    input wire logic               busy_write_one,
    input wire logic               int_enable,
    input wire logic               external_start_pin,
    input wire logic               conversion_busy_bit,
    input wire logic               conversion_done_flag,
    input wire logic               interrupt_request,
    input wire logic               track_active,
    input wire logic               single_ended_mode,
    input wire logic [7:0]         result_high_byte,
    input wire logic [7:0]         result_low_byte
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    logic idle_on;
    assign idle_on = converter_enable_bit && !conversion_busy_bit;

    a_off_idle: assert property (!converter_enable_bit |=> !conversion_busy_bit && !track_active)
        else $error("busy or tracking while disabled");
    a_mode_sel: assert property (converter_enable_bit |=>
        single_ended_mode == ($past(negative_input_select) == NEG_GND_CODE)) else $error("mode wrong");
    a_sw_start: assert property (idle_on && start_source_field == 3'h0 && busy_write_one |=>
        conversion_busy_bit) else $error("software start missed");
    a_pin_start: assert property (idle_on && start_source_field == 3'h4 && $rose(external_start_pin) |=>
        conversion_busy_bit) else $error("pin start missed");
    a_bad_code: assert property (start_source_field[2:1] == 2'b11 && !conversion_busy_bit |=>
        !conversion_busy_bit) else $error("unused code started");
    a_irq_level: assert property (interrupt_request == (conversion_done_flag && $past(int_enable)))
        else $error("irq not done and enable");
    a_result_hold: assert property (!$fell(conversion_busy_bit) |-> $stable(result_high_byte) &&
        $stable(result_low_byte)) else $error("result moved outside completion");
    a_conv_len: assert property ($rose(conversion_busy_bit) && conv_clock_divider == 5'h00 &&
        !tracking_mode_bit |-> conversion_busy_bit[*8] ##1 conversion_busy_bit ##1 conversion_busy_bit
        ##1 !conversion_busy_bit) else $error("conversion length wrong");
    a_lp_track: assert property ($rose(conversion_busy_bit) && tracking_mode_bit &&
        start_source_field != 3'h4 |-> track_active[*2]) else $error("no tracking before convert");
endmodule // sarc_ctrl_asserts

// ---- sarc_fmt.sv ----
// result formatter: code to high/low byte pair, combinational
// assumes the caller registers the outputs
`include "sarc_consts.svh"
module sarc_fmt (
    input  wire logic [`SARC_RES_BITS-1:0] code,
    input  wire logic                      diff_mode,
    input  wire logic                      left_just,
    output logic      [7:0]                high_byte,
    output logic      [7:0]                low_byte
);
    logic [`SARC_RES_BITS-1:0] value;
    logic [15:0]               right_word;
    logic [15:0]               left_word;
    logic [15:0]               word;

    // sar runs offset binary; flipping the msb gives two's complement
    assign value = diff_mode ? {~code[`SARC_RES_BITS-1], code[`SARC_RES_BITS-2:0]} : code; // R3 R6

    assign right_word[`SARC_RES_BITS-1:0] = value;
    genvar i;
    generate
        for (i = `SARC_RES_BITS; i < 16; i++) begin : g_ext
            assign right_word[i] = diff_mode & value[`SARC_RES_BITS-1]; // R5 R7
        end
    endgenerate

    assign left_word = {value, 6'h00}; // R5 R8
    assign word      = left_just ? left_word : right_word; // R4
    assign high_byte = word[15:8];
    assign low_byte  = word[7:0];
endmodule // sarc_fmt

// ---- sarc_pkg.sv ----
// types shared by the converter control modules
// assumes nothing beyond the tool's package support
package sarc_pkg;

    typedef enum logic [1:0] {
        st_idle,
        st_track,
        st_convert
    } sarc_state_t;

    typedef logic [2:0] sarc_src_t;

endpackage : sarc_pkg

// ---- testbench.sv ----
// self-checking bench: result table first, then start, timing and abort cases
// assumes sarc_ctrl, its checker and the comparator model compiled before
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sarc_pkg::*;
    typedef struct packed {
        logic [4:0]  neg;
        logic        lj;
        logic [9:0]  vin;
        logic [15:0] exp;
    } sarc_row_t;
    logic       ref_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       converter_enable_bit = 1'b1;
    logic [4:0] negative_input_select = 5'h1f;
    logic       justify_select_bit = 1'b0;
    logic [4:0] conv_clock_divider = 5'h00;
    sarc_src_t  start_source_field = 3'h0;
    logic       tracking_mode_bit = 1'b0;
    logic       busy_write_one = 1'b0;
    logic       done_clear = 1'b0;
    logic       int_enable = 1'b1;
    logic       timer0_ovf = 1'b0, timer1_ovf = 1'b0, external_start_pin = 1'b0;
    logic       timer2_low_ovf = 1'b0, timer2_high_ovf = 1'b0, timer2_split8 = 1'b0;
    logic       timer3_low_ovf = 1'b0, timer3_high_ovf = 1'b0, timer3_split8 = 1'b0;
    logic       cmp_above, conversion_busy_bit, conversion_done_flag, interrupt_request;
    logic       track_active, single_ended_mode;
    logic [9:0] sar_trial_code;
    logic [9:0] level = 10'h000;
    logic [7:0] result_high_byte, result_low_byte;
    sarc_row_t  rows [9];
    int         fails = 0;
    int         tests_run = 0;
    int         n;

    sarc_ctrl i_dut (.*);
    sarc_cmp_model i_far (.sar_trial_code, .level, .cmp_above);
    always #25 ref_clk = ~ref_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // w asks for the overflow byte that the timer width does not use
    task automatic fire(input sarc_src_t s, input logic w);
        @(posedge ref_clk);
        done_clear <= 1'b1;
        case (s)
            3'h0: busy_write_one <= 1'b1;
            3'h1: timer0_ovf <= 1'b1;
            3'h2: {timer2_low_ovf, timer2_high_ovf} <= (timer2_split8 ^ w) ? 2'b10 : 2'b01;
            3'h3: timer1_ovf <= 1'b1;
            3'h4: external_start_pin <= 1'b1;
            default: {timer3_low_ovf, timer3_high_ovf} <= (timer3_split8 ^ w) ? 2'b10 : 2'b01;
        endcase
        @(posedge ref_clk);
        {done_clear, busy_write_one, timer0_ovf, timer1_ovf, external_start_pin} <= 5'h00;
        {timer2_low_ovf, timer2_high_ovf, timer3_low_ovf, timer3_high_ovf} <= 4'h0;
        #1;
    endtask
    task automatic await_done(output int cnt);
        int k;
        k = 0;
        cnt = 0;
        while (conversion_busy_bit !== 1'b1 && k < 8) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        while (conversion_busy_bit === 1'b1 && cnt < 400) begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end
    endtask
    task automatic setup(input sarc_src_t s, input logic tm, input logic [4:0] d);
        @(posedge ref_clk);
        start_source_field <= s;
        tracking_mode_bit <= tm;
        conv_clock_divider <= d;
    endtask
    task automatic idle_chk();
        repeat (3) @(posedge ref_clk);
        #1;
        chk(16'(conversion_busy_bit), 16'h0000);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        close_out();
    end

    initial begin
        rows[0] = '{5'h1f, 1'b0, 10'h3ff, 16'h03ff};
        rows[1] = '{5'h1f, 1'b1, 10'h3ff, 16'hffc0};
        rows[2] = '{5'h1f, 1'b1, 10'h200, 16'h8000};
        rows[3] = '{5'h1f, 1'b0, 10'h100, 16'h0100};
        rows[4] = '{5'h00, 1'b0, 10'h3ff, 16'h01ff};
        rows[5] = '{5'h00, 1'b1, 10'h3ff, 16'h7fc0};
        rows[6] = '{5'h00, 1'b0, 10'h001, 16'hfe01};
        rows[7] = '{5'h00, 1'b1, 10'h000, 16'h8000};
        rows[8] = '{5'h00, 1'b0, 10'h100, 16'hff00};
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            setup(sarc_src_t'(i % 6), 1'b0, 5'h00);
            negative_input_select <= rows[i].neg;
            justify_select_bit <= rows[i].lj;
            level <= rows[i].vin;
            fire(sarc_src_t'(i % 6), 1'b0);
            await_done(n);
            chk({result_high_byte, result_low_byte}, rows[i].exp);
            chk(16'(sar_trial_code), 16'(rows[i].vin));
            chk(16'(single_ended_mode), 16'(rows[i].neg == 5'h1f));
            chk({14'h0000, conversion_done_flag, interrupt_request}, 16'h0003);
        end
        idle_chk();
        chk(16'(track_active), 16'h0001);
        // a second request while busy must leave nothing pending
        setup(3'h0, 1'b0, 5'h00);
        fire(3'h0, 1'b0);
        fire(3'h0, 1'b0);
        await_done(n);
        // the second call returns two edges after the start edge
        chk(16'(n), 16'd8);
        idle_chk();
        for (int d = 0; d < 32; d += 31) begin
            setup(3'h0, 1'b0, 5'(d));
            fire(3'h0, 1'b0);
            await_done(n);
            chk(16'(n >= 9 * d + 10 && n <= 10 * d + 10), 16'h0001);
        end
        setup(3'h0, 1'b1, 5'h00);
        fire(3'h0, 1'b0);
        await_done(n);
        chk(16'(n >= 12 && n <= 14), 16'h0001);
        setup(3'h4, 1'b1, 5'h00);
        idle_chk();
        chk(16'(track_active), 16'h0001);
        fire(3'h4, 1'b0);
        await_done(n);
        chk(16'(n), 16'd10);
        for (int t = 2; t < 6; t += 3) begin
            setup(sarc_src_t'(t), 1'b0, 5'h00);
            timer2_split8 <= 1'b1;
            timer3_split8 <= 1'b1;
            fire(sarc_src_t'(t), 1'b1);
            idle_chk();
            fire(sarc_src_t'(t), 1'b0);
            await_done(n);
            chk(16'(n), 16'd10);
        end
        for (int c = 6; c < 8; c++) begin
            setup(sarc_src_t'(c), 1'b0, 5'h00);
            for (int s = 0; s < 6; s++) fire(sarc_src_t'(s), 1'b0);
            idle_chk();
        end
        setup(3'h0, 1'b0, 5'h01);
        fire(3'h0, 1'b0);
        repeat (4) @(posedge ref_clk);
        converter_enable_bit <= 1'b0;
        idle_chk();
        chk({14'h0000, conversion_done_flag, track_active}, 16'h0000);
        chk({result_high_byte, result_low_byte}, 16'hff00);
        @(posedge ref_clk);
        converter_enable_bit <= 1'b1;
        fire(3'h0, 1'b0);
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b0;
        #1;
        chk({7'h00, conversion_busy_bit, result_high_byte}, 16'h0000);
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        fire(3'h0, 1'b0);
        await_done(n);
        chk({result_high_byte, result_low_byte}, 16'hff00);
        // done stays set, request follows the enable down
        @(posedge ref_clk);
        int_enable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({14'h0000, conversion_done_flag, interrupt_request}, 16'h0002);
        close_out();
    end
endmodule // testbench

bind sarc_ctrl sarc_ctrl_asserts #(.NEG_GND_CODE(NEG_GND_CODE)) i_chk (.*);
